// ### rtl/smp_packer.sv
// super-frame mode packer: checks four mode codes, emits four packets
// assumes same-clock encoder and formatter logic, apb from software
`timescale 1ns/1ps
module smp_packer (
  input  wire  logic             mclk_i,
  input  wire  logic             arst_n_i,
  input  wire  logic             psel_i,
  input  wire  logic             penable_i,
  input  wire  logic             pwrite_i,
  input  wire  logic [7:0]       paddr_i,
  input  wire  logic [31:0]      pwdata_i,
  output logic       [31:0]      prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire  logic             sf_valid_i,
  output logic                   sf_ready_o,
  input  wire  smp_pkg::smp_sf_t sf_i,
  output logic                   pkt_valid_o,
  input  wire  logic             pkt_ready_i,
  output smp_pkg::smp_pkt_t      pkt_o,
  output logic                   irq_o
);
  // ==========================================
  // state and declarations
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_send = 2'b10
  } smp_state_t;

  smp_state_t                    state;
  smp_state_t                    next_state;
  smp_pkg::smp_sf_t              held;
  logic [1:0]                    idx;
  logic                          legal;
  logic                          take;
  logic                          pkt_fire;
  logic                          last_fire;
  logic                          ev_done;
  logic                          ev_err;
  logic                          enable;
  logic [3:0]                    rate;
  logic [smp_pkg::ST_W-1:0]      status;
  logic [smp_pkg::ST_W-1:0]      mask;
  logic [smp_pkg::ST_W-1:0]      rd_snap;
  logic                          last_err;
  smp_pkg::smp_modes_t           last_modes;
  logic [smp_pkg::BITS_W-1:0]    total_bits;
  logic [smp_pkg::BITS_W-1:0]    vq_bits;
  logic [smp_pkg::BITS_W-1:0]    quarter;
  logic                          setup;
  logic                          access;
  logic                          mapped;

  // ==========================================
  // budget arithmetic
  function automatic logic [smp_pkg::BITS_W-1:0] total_of(input logic [3:0] r);
    total_of = smp_pkg::TOT_BASE
             + smp_pkg::BITS_W'(r) * smp_pkg::TOT_STEP;
  endfunction

  function automatic logic [smp_pkg::BITS_W-1:0] fixed_of(input logic [3:0] r);
    logic [smp_pkg::BITS_W-1:0] mid;
    mid = (r >= smp_pkg::MID_SWITCH) ? smp_pkg::B_MID_HI : smp_pkg::B_MID_LO;
    fixed_of = smp_pkg::B_MODE + smp_pkg::B_GGAIN + smp_pkg::B_GAIN
             + smp_pkg::B_UNUSED + mid + smp_pkg::B_HF_ISF
             + smp_pkg::B_HF_GAIN + smp_pkg::B_HF_CORR;
  endfunction

  // stereo 1024 window, 160..640 bits
  assign total_bits = total_of(rate);
  assign vq_bits    = total_bits - fixed_of(rate);
  // four packets of equal share
  assign quarter    = {2'b00, total_bits[smp_pkg::BITS_W-1:2]};

  // ==========================================
  // legality of incoming modes
  smp_mode_check smp_mode_check_i (
    .modes_i (sf_i.modes),
    .legal_o (legal)
  );

  assign sf_ready_o  = (state == st_idle) & enable;
  assign take        = sf_valid_i & sf_ready_o;
  assign pkt_valid_o = (state == st_send);
  assign pkt_fire    = pkt_valid_o & pkt_ready_i;
  assign last_fire   = pkt_fire & (idx == 2'(smp_pkg::FRAMES - 1));
  // illegal set is dropped and flagged
  assign ev_err      = take & ~legal;
  assign ev_done     = last_fire;

  // ==========================================
  // sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
      begin
        if (take & legal)
        begin
          next_state = st_send;
        end
      end
      st_send:
      begin
        if (last_fire)
        begin
          next_state = st_idle;
        end
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= st_idle;
    end
    else
    begin
      state <= next_state;
    end
  end

  // one super-frame of four frames, index 0..3
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      idx  <= 2'h0;
      held <= '0;
    end
    else if (take & legal)
    begin
      idx  <= 2'h0;
      held <= sf_i;
    end
    else if (pkt_fire)
    begin
      idx <= idx + 2'h1;
    end
  end

  // ==========================================
  // packet register
  function automatic smp_pkg::smp_pkt_t pkt_of(input smp_pkg::smp_sf_t s,
                                               input logic [1:0] i,
                                               input logic [smp_pkg::BITS_W-1:0] q);
    smp_pkg::smp_pkt_t p;
    p.idx       = i;
    p.mode      = s.modes[i];
    p.block_len = smp_pkg::block_of(s.modes[i]);
    p.lookahead = smp_pkg::lookahead_of(s.modes[i]);
    p.size      = q;
    p.payload   = s.payload[i*smp_pkg::PAY_W +: smp_pkg::PAY_W];
    pkt_of = p;
  endfunction

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pkt_o <= '0;
    end
    else if (take & legal)
    begin
      // own mode per frame, 11 for all-long
      pkt_o <= pkt_of(sf_i, 2'h0, quarter);
    end
    else if (pkt_fire & ~last_fire)
    begin
      pkt_o <= pkt_of(held, idx + 2'h1, quarter);
    end
  end

  // ==========================================
  // apb slave
  assign setup     = psel_i & ~penable_i;
  assign access    = psel_i & penable_i;
  assign pready_o  = access;
  assign mapped    = (paddr_i == smp_pkg::A_CTRL) | (paddr_i == smp_pkg::A_STATUS)
                   | (paddr_i == smp_pkg::A_MASK) | (paddr_i == smp_pkg::A_BUDGET)
                   | (paddr_i == smp_pkg::A_LAST);
  assign pslverr_o = access & ~mapped;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
      rd_snap  <= '0;
    end
    else if (setup)
    begin
      prdata_o <= 32'h0000_0000;
      rd_snap  <= '0;
      if (paddr_i == smp_pkg::A_CTRL)
      begin
        prdata_o[smp_pkg::CTRL_EN] <= enable;
        prdata_o[smp_pkg::RATE_LSB +: 4] <= rate;
      end
      else if (paddr_i == smp_pkg::A_STATUS)
      begin
        prdata_o[smp_pkg::ST_W-1:0] <= status;
        rd_snap <= pwrite_i ? '0 : status;
      end
      else if (paddr_i == smp_pkg::A_MASK)
      begin
        prdata_o[smp_pkg::ST_W-1:0] <= mask;
      end
      else if (paddr_i == smp_pkg::A_BUDGET)
      begin
        prdata_o[smp_pkg::BITS_W-1:0] <= total_bits;
        prdata_o[smp_pkg::VQ_LSB +: smp_pkg::BITS_W] <= vq_bits;
      end
      else if (paddr_i == smp_pkg::A_LAST)
      begin
        prdata_o[7:0] <= last_modes;
        prdata_o[smp_pkg::LAST_ERR] <= last_err;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      enable <= 1'b0;
      rate   <= 4'h0;
      mask   <= '0;
    end
    else if (access & pwrite_i)
    begin
      if (paddr_i == smp_pkg::A_CTRL)
      begin
        enable <= pwdata_i[smp_pkg::CTRL_EN];
        rate   <= pwdata_i[smp_pkg::RATE_LSB +: 4];
      end
      else if (paddr_i == smp_pkg::A_MASK)
      begin
        mask <= pwdata_i[smp_pkg::ST_W-1:0];
      end
    end
  end

  // ==========================================
  // status, last super-frame and interrupt
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status <= '0;
    end
    else
    begin
      // new events win over the read clear
      status <= (status & ~((access & ~pwrite_i) ? rd_snap : '0))
              | {ev_err, ev_done};
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      last_modes <= '0;
      last_err   <= 1'b0;
    end
    else if (take)
    begin
      last_modes <= sf_i.modes;
      last_err   <= ~legal;
    end
  end

  assign irq_o = |(status & mask);

  // ==========================================
  // assertions
  sequence s_accept;
    take & legal;
  endsequence

  sequence s_four;
    pkt_valid_o & (pkt_o.idx == 2'h0);
  endsequence

  property p_refuse;
    @(posedge mclk_i) disable iff (!arst_n_i)
    take & ~legal |=> (state == st_idle) & status[smp_pkg::ST_ERR];
  endproperty
  a_refuse: assert property (p_refuse) else $error("illegal set packed");

  property p_start;
    @(posedge mclk_i) disable iff (!arst_n_i)
    s_accept |=> s_four;
  endproperty
  a_start: assert property (p_start) else $error("first packet missing");

  property p_end;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pkt_fire & (pkt_o.idx == 2'h3) |=> ~pkt_valid_o ##0 status[smp_pkg::ST_DONE];
  endproperty
  a_end: assert property (p_end) else $error("more than four packets");

  property p_size;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pkt_valid_o & $past(pkt_valid_o)
      |-> (pkt_o.size == $past(pkt_o.size)) & (pkt_o.idx == idx);
  endproperty
  a_size: assert property (p_size) else $error("packet size differs");

  property p_own;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pkt_valid_o |-> pkt_o.mode == held.modes[pkt_o.idx];
  endproperty
  a_own: assert property (p_own) else $error("packet mode not its frame");

  property p_pair;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pkt_valid_o & (pkt_o.mode == smp_pkg::transform_medium_mode)
      |-> held.modes[{pkt_o.idx[1], ~pkt_o.idx[0]}] == smp_pkg::transform_medium_mode;
  endproperty
  a_pair: assert property (p_pair) else $error("medium not paired");

  property p_long;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pkt_valid_o & (pkt_o.mode == smp_pkg::transform_long_mode)
      |-> (held.modes == {4{smp_pkg::transform_long_mode}}) & (pkt_o.mode == 2'b11);
  endproperty
  a_long: assert property (p_long) else $error("long mode mixed");

  property p_look;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pkt_valid_o & (pkt_o.mode == smp_pkg::transform_medium_mode)
      |-> (pkt_o.lookahead == smp_pkg::LA_MED) & (pkt_o.block_len == smp_pkg::LEN_MED);
  endproperty
  a_look: assert property (p_look) else $error("medium look-ahead wrong");

  property p_budget;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (total_bits >= smp_pkg::TOT_BASE) & (vq_bits < total_bits);
  endproperty
  a_budget: assert property (p_budget) else $error("budget sum wrong");

  property p_irq;
    @(posedge mclk_i) disable iff (!arst_n_i)
    ev_err & mask[smp_pkg::ST_ERR] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("error event lost");

  property p_legal;
    @(posedge mclk_i) disable iff (!arst_n_i)
    s_accept |-> (sf_i.modes[0] == smp_pkg::transform_long_mode)
                 == (sf_i.modes[3] == smp_pkg::transform_long_mode);
  endproperty
  a_legal: assert property (p_legal) else $error("illegal set accepted");
endmodule

// ### rtl/smp_pkg.sv
// package of the super-frame mode packer: modes, register map, budget
// assumes a single 10 MHz clock and an apb register port
package smp_pkg;
  localparam int unsigned FRAMES   = 4;
  localparam int unsigned SF_LEN   = 1024;
  localparam int unsigned FR_LEN   = 256;
  localparam int unsigned MED_LEN  = 512;
  localparam int unsigned PAY_W    = 32;
  localparam int unsigned LEN_W    = 11;
  localparam int unsigned LA_W     = 8;
  localparam int unsigned BITS_W   = 10;

  // per-frame mode codes
  typedef enum logic [1:0] {
    predictive_time_domain_mode = 2'h0,
    transform_short_mode        = 2'h1,
    transform_medium_mode       = 2'h2,
    transform_long_mode         = 2'h3
  } smp_mode_t;

  typedef smp_mode_t [FRAMES-1:0] smp_modes_t;

  typedef struct packed {
    smp_modes_t             modes;
    logic [FRAMES*PAY_W-1:0] payload;
  } smp_sf_t;

  typedef struct packed {
    logic [1:0]        idx;
    smp_mode_t         mode;
    logic [LEN_W-1:0]  block_len;
    logic [LA_W-1:0]   lookahead;
    logic [BITS_W-1:0] size;
    logic [PAY_W-1:0]  payload;
  } smp_pkt_t;

  localparam logic [LA_W-1:0]  LA_NONE  = 8'h00;
  localparam logic [LA_W-1:0]  LA_SHORT = 8'h20;
  localparam logic [LA_W-1:0]  LA_MED   = 8'h40;
  localparam logic [LA_W-1:0]  LA_LONG  = 8'h80;
  localparam logic [LEN_W-1:0] LEN_FR   = 11'h100;
  localparam logic [LEN_W-1:0] LEN_MED  = 11'h200;
  localparam logic [LEN_W-1:0] LEN_SF   = 11'h400;

  localparam logic [BITS_W-1:0] TOT_BASE  = 10'h0A0;
  localparam logic [BITS_W-1:0] TOT_STEP  = 10'h020;
  localparam logic [BITS_W-1:0] B_MODE    = 10'h008;
  localparam logic [BITS_W-1:0] B_GGAIN   = 10'h007;
  localparam logic [BITS_W-1:0] B_GAIN    = 10'h007;
  localparam logic [BITS_W-1:0] B_UNUSED  = 10'h004;
  localparam logic [BITS_W-1:0] B_MID_LO  = 10'h018;
  localparam logic [BITS_W-1:0] B_MID_HI  = 10'h030;
  localparam logic [BITS_W-1:0] B_HF_ISF  = 10'h009;
  localparam logic [BITS_W-1:0] B_HF_GAIN = 10'h007;
  localparam logic [BITS_W-1:0] B_HF_CORR = 10'h030;
  localparam logic [3:0]        MID_SWITCH = 4'h7;

  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MASK   = 8'h08;
  localparam logic [7:0] A_BUDGET = 8'h0C;
  localparam logic [7:0] A_LAST   = 8'h10;

  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned RATE_LSB  = 4;
  localparam int unsigned ST_DONE   = 0;
  localparam int unsigned ST_ERR    = 1;
  localparam int unsigned ST_W      = 2;
  localparam int unsigned VQ_LSB    = 16;
  localparam int unsigned LAST_ERR  = 8;

  function automatic logic [LA_W-1:0] lookahead_of(input smp_mode_t m);
    case (m)
      transform_short_mode:  lookahead_of = LA_SHORT;
      transform_medium_mode: lookahead_of = LA_MED;
      transform_long_mode:   lookahead_of = LA_LONG;
      default:               lookahead_of = LA_NONE;
    endcase
  endfunction

  function automatic logic [LEN_W-1:0] block_of(input smp_mode_t m);
    case (m)
      transform_medium_mode: block_of = LEN_MED;
      transform_long_mode:   block_of = LEN_SF;
      default:               block_of = LEN_FR;
    endcase
  endfunction
endpackage

// ### rtl/smp_mode_check.sv
// legality check of one super-frame's four mode codes
// assumes the codes are stable while it is read; purely combinational
`timescale 1ns/1ps
module smp_mode_check (
  input  wire smp_pkg::smp_modes_t modes_i,
  output logic                     legal_o
);
  // ==========================================
  // pairing and all-four checks
  logic any_long;
  logic all_long;
  logic pair_ok;
  logic bad_med;

  always_comb
  begin
    any_long = 1'b0;
    all_long = 1'b1;
    bad_med  = 1'b0;
    for (int i = 0; i < smp_pkg::FRAMES; i++)
    begin
      any_long = any_long | (modes_i[i] == smp_pkg::transform_long_mode);
      all_long = all_long & (modes_i[i] == smp_pkg::transform_long_mode);
    end
    // medium only as frames 0+1 or 2+3
    pair_ok = 1'b1;
    for (int p = 0; p < smp_pkg::FRAMES; p += 2)
    begin
      bad_med = (modes_i[p] == smp_pkg::transform_medium_mode)
             != (modes_i[p+1] == smp_pkg::transform_medium_mode);
      pair_ok = pair_ok & ~bad_med;
    end
    // long only as a whole super-frame; 16+4+4+1+1 = 26 legal sets
    legal_o = all_long | (~any_long & pair_ok);
  end
endmodule

// ### sim/smp_fmt_model.sv
// formatter model at the packer's packet side: paces ready, checks order
// assumes the packer's clock and reset; slow_i comes from the bench
`timescale 1ns/1ps
module smp_fmt_model (
  input  wire  logic              mclk_i,
  input  wire  logic              arst_n_i,
  input  wire  logic              slow_i,
  input  wire  logic              pkt_valid_i,
  input  wire  smp_pkg::smp_pkt_t pkt_i,
  output logic                    pkt_ready_o,
  output logic                    order_err_o
);
  logic [1:0] pace;
  logic [1:0] next_idx;
  // ==========================================
  // pacing, then index order of taken packets
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pace        <= 2'h0;
      pkt_ready_o <= 1'b0;
      next_idx    <= 2'h0;
      order_err_o <= 1'b0;
    end
    else
    begin
      pace        <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      pkt_ready_o <= !slow_i || (pace == 2'h1);
      if (pkt_valid_i && pkt_ready_o)
      begin
        next_idx <= next_idx + 2'h1;
        if (pkt_i.idx !== next_idx)
          order_err_o <= 1'b1;
      end
    end
  end
endmodule

// ### sim/smp_packer_tb.sv
// self-checking bench of the super-frame mode packer
// assumes the packer, its package and the formatter model
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module smp_packer_tb;
  logic              mclk_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sf_valid = 1'b0;
  logic              sf_ready;
  smp_pkg::smp_sf_t  sf = '0;
  logic              pkt_valid;
  logic              pkt_ready;
  smp_pkg::smp_pkt_t pkt;
  smp_pkg::smp_pkt_t got_x;
  logic              irq;
  logic              slow = 1'b0;
  logic              order_err;
  logic [31:0]       rnd = 32'hAADD;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  smp_pkg::smp_pkt_t exp_q[$];

  smp_packer smp_packer_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sf_valid_i(sf_valid),
    .sf_ready_o(sf_ready), .sf_i(sf), .pkt_valid_o(pkt_valid), .pkt_ready_i(pkt_ready),
    .pkt_o(pkt), .irq_o(irq));
  smp_fmt_model smp_fmt_model_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .slow_i(slow),
    .pkt_valid_i(pkt_valid), .pkt_i(pkt), .pkt_ready_o(pkt_ready), .order_err_o(order_err));

  initial
  begin
    forever #50 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic pok(input logic [3:0] p);
    pok = (p == 4'hA) || !(p[1] | p[3]);
  endfunction

  task automatic results;
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // apb master: hold request until pready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================
  // packet monitor: oldest note against each taken packet
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      results();
    end
    else if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
    begin
      got_x = (exp_q.size() > 0) ? exp_q.pop_front() : smp_pkg::smp_pkt_t'(~pkt);
      `CHK(pkt, got_x)
    end
  end

  // ==========================================
  // every mode combination, random rate, mask and pacing
  initial
  begin
    logic [31:0]       v;
    logic              e;
    logic [7:0]        c;
    logic [3:0]        rate;
    logic [9:0]        tot;
    logic [1:0]        msk;
    logic              ok;
    logic [8:0]        n_done;
    smp_pkg::smp_pkt_t x;
    n_done = 9'h000;
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, smp_pkg::A_CTRL, 32'h0, v, e);
    `CHK(v, 32'h0)
    apb(1'b0, 8'h20, 32'h0, v, e);
    `CHK({e, v}, 33'h100000000)
    for (int i = 0; i < 256; i++)
    begin
      c = i[7:0];
      rnd = lfsr(rnd);
      rate = rnd[3:0];
      msk = rnd[5:4];
      slow <= rnd[6];
      tot = 10'h0A0 + {rate, 5'h00};
      ok = (c == 8'hFF) || (pok(c[3:0]) && pok(c[7:4]));
      apb(1'b1, smp_pkg::A_CTRL, {24'h0, rate, 4'h1}, v, e);
      apb(1'b1, smp_pkg::A_MASK, {30'h0, msk}, v, e);
      apb(1'b0, smp_pkg::A_BUDGET, 32'h0, v, e);
      `CHK(v, {6'h00, tot - 10'h072 - ((rate < 4'h7) ? 10'h000 : 10'h018), 6'h00, tot})
      sf.modes <= smp_pkg::smp_modes_t'(c);
      for (int k = 0; k < 4; k++)
      begin
        rnd = lfsr(rnd);
        sf.payload[k*32 +: 32] <= rnd;
        x.idx = k[1:0];
        x.mode = smp_pkg::smp_mode_t'(c[2*k +: 2]);
        x.block_len = (x.mode == 2'h2) ? 11'h200 : (x.mode == 2'h3) ? 11'h400 : 11'h100;
        x.lookahead = (x.mode == 2'h0) ? 8'h00 : 8'h10 << x.mode;
        x.size = tot >> 2;
        x.payload = rnd;
        if (ok)
          exp_q.push_back(x);
      end
      sf_valid <= 1'b1;
      @(posedge mclk_i);
      while (sf_ready !== 1'b1) @(posedge mclk_i);
      sf_valid <= 1'b0;
      sf.payload <= ~sf.payload;
      @(posedge mclk_i);
      while (sf_ready !== 1'b1) @(posedge mclk_i);
      @(posedge mclk_i);
      `CHK(irq, |({!ok, ok} & msk))
      apb(1'b0, smp_pkg::A_STATUS, 32'h0, v, e);
      `CHK(v, {30'h0, !ok, ok})
      n_done = n_done + {8'h00, v[0]};
      apb(1'b0, smp_pkg::A_LAST, 32'h0, v, e);
      `CHK({irq, v}, {1'b0, 23'h0, !ok, c})
    end
    repeat (4) @(posedge mclk_i);
    `CHK(n_done, 9'h01A)
    `CHK(exp_q.size(), 0)
    `CHK(order_err, 1'b0)
    results();
  end
endmodule
